// [include/epi_pkg.sv]
// Behaviour
// R01: pin activity raises requests even when the pin is driven as an output.
// R02: pin-change request when any masked-in input of sixteen toggles.
// R03: pin-change detection works without the I/O clock, for wake from sleep.
// R04: sense field 00 low level, 01 any change, 10 falling, 11 rising.
// R05: level mode keeps the request up while the pin is held low.
// R06: edge modes are recognised only while the I/O clock runs.
// R07: low level on pin a is detected without a clock, waking from any sleep.
// R08: a waking level that ends early wakes the part but raises no request.
// R09: request reaches the cpu only with global enable and its own mask bit; o_req_pc uses global enable only, group enables gate its flag.
// R10: pin sampled before edge detection; pulses over one clock are caught.
// R11: source holds a low level until the current instruction completes.
// R12: sense field in bits 1:0 of mcu_control, reset value zero.
// R13: edge flag set on trigger, cleared by service or write-one, zero in level mode.
// R14: inputs 11:8 gated by group enable b, 7:0 and 15:12 by group enable a.
// R15: external pins go through two flip-flops, then compare with previous sample.
package epi_pkg;
  localparam logic [7:0] ADDR_MCU_CONTROL = 8'h35;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h3b;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h3a;
  localparam logic [7:0] ADDR_PC_MASK_A = 8'h23;
  localparam logic [7:0] ADDR_PC_MASK_B = 8'h22;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h40;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h41;
  localparam logic [7:0] MCU_CONTROL_RST = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] PC_MASK_A_RST = 8'hc8;
  localparam logic [7:0] PC_MASK_B_RST = 8'hff;
  localparam logic [7:0] EVT_MASK_RST = 8'h00;
  localparam int SENSE_LSB = 0;
  localparam int EN_PIN_B_BIT = 7;
  localparam int EN_PIN_A_BIT = 6;
  localparam int EN_PC_GRP_A_BIT = 5;
  localparam int EN_PC_GRP_B_BIT = 4;
  localparam int FLAG_PIN_B_BIT = 7;
  localparam int FLAG_PIN_A_BIT = 6;
  localparam int FLAG_PC_BIT = 5;
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
endpackage

// [rtl/epi_irq_detect.sv]
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module epi_irq_detect #(
  parameter int PC_WIDTH = 16
) (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // pins (sampled pad level, whether driven by us or not)
  input wire logic i_ext_irq_pin_a,
  input wire logic i_ext_irq_pin_b,
  input wire logic [PC_WIDTH-1:0] i_pin_change_inputs,
  // cpu side
  input wire logic i_cpu_status_word_ie,
  input wire logic i_io_clk_run,
  input wire logic i_ack_pin_a,
  input wire logic i_ack_pin_b,
  input wire logic i_ack_pc,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // requests
  output logic o_req_pin_a,
  output logic o_req_pin_b,
  output logic o_req_pc,
  output logic o_wake,
  output logic o_irq
);
  // the group gating and mask layout serve exactly sixteen inputs
  if (PC_WIDTH != 16) begin : g_width_check
    $error("PC_WIDTH must be 16");
  end

  logic [7:0] mcu_control_r;
  logic [7:0] irq_enable_r;
  logic [7:0] pc_mask_a_r;
  logic [7:0] pc_mask_b_r;
  logic [2:0] flags_r;
  logic [2:0] evt_status_r;
  logic [2:0] evt_mask_r;
  logic [7:0] rdata_r;
  logic [1:0] pin_prev_r;
  logic [PC_WIDTH-1:0] pc_sync1_r;
  logic [PC_WIDTH-1:0] pc_sync2_r;
  logic [PC_WIDTH-1:0] pc_prev_r;

  // register decode
  wire sel_ctl = i_addr == epi_pkg::ADDR_MCU_CONTROL;
  wire sel_en = i_addr == epi_pkg::ADDR_IRQ_ENABLE;
  wire sel_flg = i_addr == epi_pkg::ADDR_IRQ_FLAGS;
  wire sel_mka = i_addr == epi_pkg::ADDR_PC_MASK_A;
  wire sel_mkb = i_addr == epi_pkg::ADDR_PC_MASK_B;
  wire sel_st = i_addr == epi_pkg::ADDR_EVT_STATUS;
  wire sel_em = i_addr == epi_pkg::ADDR_EVT_MASK;

  // external pins: sync then compare with previous sample
  wire [1:0] pin_raw = {i_ext_irq_pin_b, i_ext_irq_pin_a}; // [R01]
  wire [1:0] pin_s;
  epi_sync2 #(.WIDTH(2)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_d(pin_raw),
    .o_q(pin_s)
  ); // [R15] [R10]

  wire [1:0] sense = mcu_control_r[epi_pkg::SENSE_LSB +: 2]; // [R12]
  wire sense_level = sense == epi_pkg::SENSE_LOW;
  wire [1:0] rise = pin_s & ~pin_prev_r;
  wire [1:0] fall = ~pin_s & pin_prev_r;
  logic [1:0] edge_hit;
  always_comb begin
    unique case (sense) // [R04]
      epi_pkg::SENSE_ANY: edge_hit = rise | fall;
      epi_pkg::SENSE_FALL: edge_hit = fall;
      epi_pkg::SENSE_RISE: edge_hit = rise;
      default: edge_hit = 2'h0;
    endcase
  end
  wire [1:0] edge_ok = i_io_clk_run ? edge_hit : 2'h0; // [R06]
  // level mode uses the raw pad level: no clock needed for detection
  wire [1:0] level_hit = sense_level ? ~pin_raw : 2'h0; // [R05] [R07]

  // pin-change: group gating and per-input mask
  wire [15:0] pc_mask = {pc_mask_b_r, pc_mask_a_r};
  wire grp_a = irq_enable_r[epi_pkg::EN_PC_GRP_A_BIT];
  wire grp_b = irq_enable_r[epi_pkg::EN_PC_GRP_B_BIT];
  wire [15:0] grp_en = {{4{grp_a}}, {4{grp_b}}, {8{grp_a}}}; // [R14]
  wire [15:0] pc_armed = pc_mask & grp_en; // [R02]
  // asynchronous wake: any armed input differing from its last sample
  wire [15:0] pc_diff = (i_pin_change_inputs ^ pc_prev_r) & pc_armed; // [R03]
  wire [15:0] pc_toggle = (pc_sync2_r ^ pc_prev_r) & pc_armed; // [R02]
  wire pc_hit = |pc_toggle;

  // write-one clear with set winning
  wire [2:0] w1c = (i_wr && sel_flg) ?
    {i_wdata[epi_pkg::FLAG_PIN_B_BIT], i_wdata[epi_pkg::FLAG_PIN_A_BIT],
     i_wdata[epi_pkg::FLAG_PC_BIT]} : 3'h0;
  wire [2:0] ack = {i_ack_pin_b, i_ack_pin_a, i_ack_pc};
  wire [2:0] set_ev = {edge_ok[1], edge_ok[0], pc_hit};
  wire [2:0] flags_nxt = sense_level ? {2'h0, set_ev[0] | (flags_r[0] & ~(w1c[0] | ack[0]))}
    : (set_ev | (flags_r & ~(w1c | ack))); // [R13]
  wire st_rd = i_rd && sel_st;
  wire [2:0] evt_nxt = set_ev | (st_rd ? 3'h0 : evt_status_r);

  wire [7:0] flags_rd = {flags_r[2], flags_r[1], flags_r[0], 5'h0};
  wire [7:0] rdata_nxt = sel_ctl ? mcu_control_r :
    sel_en ? {irq_enable_r[7:4], 4'h0} :
    sel_flg ? flags_rd :
    sel_mka ? pc_mask_a_r :
    sel_mkb ? pc_mask_b_r :
    sel_st ? {5'h0, evt_status_r} :
    sel_em ? {5'h0, evt_mask_r} : 8'h00;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mcu_control_r <= epi_pkg::MCU_CONTROL_RST; // [R12]
      irq_enable_r <= epi_pkg::IRQ_ENABLE_RST;
      pc_mask_a_r <= epi_pkg::PC_MASK_A_RST;
      pc_mask_b_r <= epi_pkg::PC_MASK_B_RST;
      evt_mask_r <= epi_pkg::EVT_MASK_RST[2:0];
    end else if (i_ce && i_wr) begin
      if (sel_ctl) mcu_control_r <= i_wdata;
      if (sel_en) irq_enable_r <= {i_wdata[7:4], 4'h0};
      if (sel_mka) pc_mask_a_r <= i_wdata;
      if (sel_mkb) pc_mask_b_r <= i_wdata;
      if (sel_em) evt_mask_r <= i_wdata[2:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flags_r <= 3'h0;
      evt_status_r <= 3'h0;
      rdata_r <= 8'h00;
      pin_prev_r <= 2'h0;
      pc_sync1_r <= '0;
      pc_sync2_r <= '0;
      pc_prev_r <= '0;
    end else if (i_ce) begin
      flags_r <= flags_nxt;
      evt_status_r <= evt_nxt;
      rdata_r <= i_rd ? rdata_nxt : 8'h00;
      pin_prev_r <= pin_s; // [R15]
      pc_sync1_r <= i_pin_change_inputs;
      pc_sync2_r <= pc_sync1_r;
      pc_prev_r <= pc_sync2_r;
    end
  end

  // request gating: level requests only while the pin stays low
  wire [1:0] en_pin = {irq_enable_r[epi_pkg::EN_PIN_B_BIT], irq_enable_r[epi_pkg::EN_PIN_A_BIT]};
  wire [1:0] pin_act = sense_level ? level_hit : flags_r[2:1]; // [R05] [R08]
  assign o_req_pin_a = i_cpu_status_word_ie & en_pin[0] & pin_act[0]; // [R09]
  assign o_req_pin_b = i_cpu_status_word_ie & en_pin[1] & pin_act[1]; // [R09]
  assign o_req_pc = i_cpu_status_word_ie & flags_r[0]; // [R09] [R02]
  // wake needs no clock; a level dropped early wakes without a request
  assign o_wake = (en_pin[0] & level_hit[0]) | (|pc_diff); // [R07] [R03] [R08]
  assign o_rdata = rdata_r;
  assign o_irq = |(evt_status_r & evt_mask_r);
endmodule
`default_nettype wire

// [rtl/epi_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser per bit
module epi_sync2 #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // data
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= '0;
      q_r <= '0;
    end else if (i_ce) begin
      meta_r <= i_d;
      q_r <= meta_r;
    end
  end

  assign o_q = q_r;
endmodule
`default_nettype wire

// [tb/epi_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module epi_checker (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // cpu and register port
  input wire logic i_cpu_status_word_ie,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // requests
  input wire logic o_req_pin_a,
  input wire logic o_req_pin_b,
  input wire logic o_req_pc
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  ie_gate_a_a: assert property (o_req_pin_a |-> i_cpu_status_word_ie)
    else $error("pin a request without ie");
  ie_gate_b_a: assert property (o_req_pin_b |-> i_cpu_status_word_ie)
    else $error("pin b request without ie");
  ie_gate_pc_a: assert property (o_req_pc |-> i_cpu_status_word_ie)
    else $error("pc request without ie");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  unmapped_zero_a: assert property (i_rd && i_addr == 8'h00 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  enable_resv_a: assert property ($past(i_rd) && $past(i_addr) == 8'h3b |-> o_rdata[3:0] == 4'h0)
    else $error("enable low nibble not zero");
  flag_resv_a: assert property ($past(i_rd) && $past(i_addr) == 8'h3a |-> o_rdata[4:0] == 5'h00)
    else $error("flag low bits not zero");
  ctrl_readback_a: assert property (i_ce && i_wr && i_addr == 8'h35 ##1 i_ce && i_rd && i_addr == 8'h35
    |=> o_rdata == $past(i_wdata, 2))
    else $error("control readback differs");
endmodule
bind epi_irq_detect epi_checker epi_checker_i (.i_sys_clk, .i_resetn, .i_ce, .i_cpu_status_word_ie,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_req_pin_a, .o_req_pin_b, .o_req_pc);
`default_nettype wire

// [tb/epi_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module epi_src_model (
  // clock
  input wire logic i_sys_clk,
  // wanted levels
  input wire logic i_lvl_a,
  input wire logic i_lvl_b,
  input wire logic [15:0] i_lvl_pc,
  // pads
  output logic o_pin_a,
  output logic o_pin_b,
  output logic [15:0] o_pc
);
  // levels move on clock edges and hold whole cycles
  always_ff @(posedge i_sys_clk) begin
    o_pin_a <= i_lvl_a;
    o_pin_b <= i_lvl_b;
    o_pc <= i_lvl_pc;
  end
endmodule
`default_nettype wire

// [tb/tb_external_pin_interrupt_detect.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_external_pin_interrupt_detect;
  logic clk = 0, rstn = 0, ie = 0, run = 1, wr = 0, rd = 0, la = 1, lb = 1, ack = 0, ce = 1;
  logic [7:0] addr = 0, wd = 0, v, ma, mb;
  logic [15:0] lpc = 0, pc, mk;
  logic pa, pb, rqa, rqb, rqc, irq, wk;
  logic [7:0] rdat;
  logic [7:0] ra [7] = '{8'h35, 8'h3b, 8'h3a, 8'h23, 8'h22, 8'h41, 8'h00};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'hc8, 8'hff, 8'h00, 8'h00};
  int n_errors = 0, comparisons = 0, k, m, e;
  always #4 clk = ~clk;
  epi_src_model epi_src_model_i (.i_sys_clk(clk), .i_lvl_a(la), .i_lvl_b(lb), .i_lvl_pc(lpc),
    .o_pin_a(pa), .o_pin_b(pb), .o_pc(pc));
  epi_irq_detect epi_irq_detect_i (.i_sys_clk(clk), .i_resetn(rstn), .i_ce(ce),
    .i_ext_irq_pin_a(pa), .i_ext_irq_pin_b(pb), .i_pin_change_inputs(pc),
    .i_cpu_status_word_ie(ie), .i_io_clk_run(run), .i_ack_pin_a(ack), .i_ack_pin_b(ack),
    .i_ack_pc(ack), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdat),
    .o_req_pin_a(rqa), .o_req_pin_b(rqb), .o_req_pc(rqc), .o_wake(wk), .o_irq(irq));
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    comparisons++;
    if (s !== x) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  // write followed by a read of the same address with no gap
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    r(a);
  endtask
  task automatic r(input logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) v = rdat;
    @(posedge clk);
  endtask
  task automatic t(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic conclude;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'hcfd0755f));
    t(12);
    rstn <= 1'b1;
    t(2);
    foreach (ra[i]) begin
      r(ra[i]);
      chk(v, rv[i]);
    end
    ce <= 1'b0;
    w(8'h35, 8'h03);
    ce <= 1'b1;
    r(8'h35);
    chk(v, 8'h00);
    wr_rd(8'h35, 8'h03);
    chk(v, 8'h03);
    w(8'h35, 8'h00);
    ie <= 1'b1;
    w(8'h3b, 8'hc0);
    la <= 1'b0;
    lb <= 1'b0;
    t(26);
    chk({6'h0, rqa, rqb}, 8'h03);
    chk({7'h0, wk}, 8'h01);
    r(8'h3a);
    chk(v, 8'h00);
    la <= 1'b1;
    lb <= 1'b1;
    t(6);
    chk({6'h0, rqa, rqb}, 8'h00);
    chk({7'h0, wk}, 8'h00);
    for (m = 0; m < 5; m++) begin
      run <= (m != 4);
      ie <= (m != 1);
      w(8'h35, (m == 4) ? 8'h02 : 8'(m));
      w(8'h3a, 8'he0);
      la <= 1'b0;
      lb <= 1'b0;
      t(6);
      chk({6'h0, rqa, rqb}, (m == 2 || m == 0) ? 8'h03 : 8'h00);
      r(8'h3a);
      chk(v, (m == 1 || m == 2) ? 8'hc0 : 8'h00);
      w(8'h3a, 8'hc0);
      la <= 1'b1;
      lb <= 1'b1;
      t(6);
      r(8'h3a);
      chk(v, (m == 1 || m == 3) ? 8'hc0 : 8'h00);
      ack <= 1'b1;
      t(1);
      ack <= 1'b0;
      r(8'h3a);
      chk(v, 8'h00);
    end
    ie <= 1'b1;
    w(8'h41, 8'h01);
    for (k = 0; k < 8; k++) begin
      ma = 8'($urandom);
      mb = 8'($urandom);
      mk = {mb, ma};
      w(8'h23, ma);
      w(8'h22, mb);
      w(8'h3b, k[0] ? 8'h10 : 8'h20);
      r(8'h40);
      w(8'h3a, 8'he0);
      m = $urandom_range(15);
      lpc[m] <= ~lpc[m];
      e = int'(mk[m] && ((m >= 8 && m <= 11) == k[0]));
      t(2);
      chk({7'h0, wk}, 8'(e));
      t(4);
      chk({7'h0, rqc}, 8'(e));
      chk({7'h0, irq}, 8'(e));
      r(8'h40);
      chk(v, 8'(e));
      chk({7'h0, irq}, 8'h00);
    end
    conclude();
  end
endmodule
`default_nettype wire
